// ==== common/ccu_pkg.sv ====
package ccu_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] CCU_OFF_CTRL  = 4'h0;
  localparam logic [3:0] CCU_OFF_VLOW  = 4'h4;
  localparam logic [3:0] CCU_OFF_VHIGH = 4'h8;
  localparam logic [3:0] CCU_OFF_STAT  = 4'hC;

  // Mode select codes held in the low nibble of ccp_control.
  localparam logic [3:0] CCU_MODE_OFF   = 4'h0;
  localparam logic [3:0] CCU_MODE_RISE  = 4'h5;
  localparam logic [3:0] CCU_MODE_SET   = 4'h8;
  localparam logic [3:0] CCU_MODE_CLR   = 4'h9;
  localparam logic [3:0] CCU_MODE_SOFT  = 4'hA;
  localparam logic [3:0] CCU_MODE_TRIG  = 4'hB;

  // Upper two mode bits pick the family of the mode.
  localparam logic [1:0] CCU_TOP_CAP = 2'h1;
  localparam logic [1:0] CCU_TOP_CMP = 2'h2;
  localparam logic [1:0] CCU_TOP_PWM = 2'h3;

  // Lower two mode bits inside the capture family.
  localparam logic [1:0] CCU_CAP_FALL = 2'h0;
  localparam logic [1:0] CCU_CAP_RISE = 2'h1;
  localparam logic [1:0] CCU_CAP_PS4  = 2'h2;
  localparam logic [1:0] CCU_CAP_PS16 = 2'h3;

  // Last prescaler count before a capture fires.
  localparam logic [3:0] CCU_PS4_LAST  = 4'h3;
  localparam logic [3:0] CCU_PS16_LAST = 4'hF;

  // Control field positions and write mask; bits 7-6 stay zero.
  localparam int         CCU_MODE_MSB   = 3;
  localparam int         CCU_DUTY_LSB   = 4;
  localparam int         CCU_DUTY_MSB   = 5;
  localparam logic [7:0] CCU_CTRL_WMASK = 8'h3F;

  // Status register bit positions.
  localparam int CCU_STAT_FLAG  = 0;
  localparam int CCU_STAT_LATCH = 1;

  // Reset values.
  localparam logic [7:0]  CCU_BYTE_RST = 8'h00;
  localparam logic [31:0] CCU_WORD_RST = 32'h0000_0000;

  // One Avalon-MM request from the master.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } ccu_avs_req_t;

  // Complete state of the unit.
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  vlow;
    logic [7:0]  vhigh;
    logic        flag;
    logic        latch;
    logic        pin_oe;
    logic [3:0]  ps_cnt;
    logic        sync1;
    logic        sync2;
    logic        pin_prev;
    logic        match_prev;
    logic        trig;
    logic        adc;
    logic [9:0]  duty;
    logic        wait_req;
    logic [31:0] rdata;
  } ccu_state_t;

endpackage

// ==== logic/ccu_capture_compare.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Mode zero turns unit off, clears state but flag, values.
// - Codes one to three do nothing.
// - 0100 captures falling, 0101 rising edges.
// - Other capture codes: every 4th, 16th rise.
// - 1000 drives pin high on match, flags.
// - 1001 drives pin low on match, flags.
// - 1010 only flags; pin left alone.
// - 1011 flags, resets timer, starts converter.
// - 11xx is PWM; duty from value_low, bits5-4.
// - Control bits 7-6 read zero always.
// - Capture copies full 16-bit timer count.
// - Every capture sets sticky flag; software clears.
// - New capture overwrites unread old value.
// - Edges seen on pin level, even driven.
// - Prescaler cleared when off or not capturing.
// - Prescale change keeps count; software zeroes first.
// - Compare runs continuously; every compare mode flags.
// - Capture/compare use timer_one; PWM timer_two.
// - Units share timer_one; PWM units independent.
// - Trigger and timer reset share one flop; both need match held to an edge.
// - Writing zero clears compare output latch.
module ccu_capture_compare
  import ccu_pkg::*;
#(
  parameter int TIMER_W = 16  // Width of the shared timer_one count.
) (
  input  wire logic         ref_clk_in,          // System clock, 20 MHz.
  input  wire logic         reset_in,            // Asynchronous reset, active high.
  input  wire ccu_avs_req_t avs_req_in,          // Avalon-MM request group.
  output logic              avs_waitrequest_out, // Avalon-MM waitrequest.
  output logic [31:0]       avs_readdata_out,    // Avalon-MM read data.
  input  wire logic [15:0]  timer_one_count_in,  // Shared timer_one count.
  input  wire logic         adc_enable_in,       // Converter is enabled.
  input  wire logic         event_pin_in,        // Level seen on the event pin.
  output logic              event_pin_out,       // Compare output latch.
  output logic              event_pin_oe_out,    // Unit drives the pin.
  output logic              event_flag_out,      // Sticky event flag.
  output logic              special_event_out,   // Special event trigger.
  output logic              timer_one_reset_out, // Reset request to timer_one.
  output logic              adc_start_out,       // Start a conversion.
  output logic [9:0]        duty_value_out       // PWM duty value for the generator.
);

  // The compare path is a fixed 16-bit register pair.
  // Other widths would need a wider value register pair and read path.
  if (TIMER_W != 16) begin : g_width_check
    $error("TIMER_W must be 16");
  end

  // Whole state, registered copy and its next value.
  ccu_state_t state_reg;
  ccu_state_t state_next;

  // Decoded mode and per-cycle events.
  logic [3:0] mode;       // Current mode select.
  logic       is_cap;     // Capture family.
  logic       is_cmp;     // Compare family.
  logic       is_pwm;     // PWM family.
  logic       rise;       // Synchronized rising edge.
  logic       fall;       // Synchronized falling edge.
  logic       cap_hit;    // Qualified capture event.
  logic       match;      // Timer equals stored value in compare.
  logic       match_evt;  // First cycle of a match.
  logic       bus_req;    // Master has a request up.
  logic       commit;     // Edge at which the access completes.
  logic       wr_ctrl;    // Control write completes in this cycle.
  logic       wr_stat;    // Status write completes in this cycle.

  // Read multiplexer; unmapped offsets read as zero.
  function automatic logic [31:0] read_mux(input logic [3:0] addr, input ccu_state_t s);
    logic [31:0] d;
    d = CCU_WORD_RST;
    unique case (addr)
      CCU_OFF_CTRL:  d[7:0] = s.ctrl;
      CCU_OFF_VLOW:  d[7:0] = s.vlow;
      CCU_OFF_VHIGH: d[7:0] = s.vhigh;
      CCU_OFF_STAT: begin
        // Status packs the sticky flag and the compare output latch.
        d[CCU_STAT_FLAG]  = s.flag;
        d[CCU_STAT_LATCH] = s.latch;
      end
      default: d = CCU_WORD_RST;
    endcase
    return d;
  endfunction

  // Next-state logic for the whole unit.
  always_comb begin
    state_next = state_reg;
    // Decoded mode and its family, taken from the upper two mode bits.
    mode       = state_reg.ctrl[CCU_MODE_MSB:0];
    is_cap     = (mode[3:2] == CCU_TOP_CAP);
    is_cmp     = (mode[3:2] == CCU_TOP_CMP);
    is_pwm     = (mode[3:2] == CCU_TOP_PWM);
    bus_req    = avs_req_in.read | avs_req_in.write;
    commit     = bus_req & ~state_reg.wait_req;
    // Completing writes, named so that the checks can leave software action out.
    wr_ctrl    = commit & avs_req_in.write & avs_req_in.byteenable[0] & (avs_req_in.address == CCU_OFF_CTRL);
    wr_stat    = commit & avs_req_in.write & avs_req_in.byteenable[0] & (avs_req_in.address == CCU_OFF_STAT);

    // Two-flop synchronizer; the pad level is used, so a driven pin
    // can also cause a capture.
    state_next.sync1    = event_pin_in;
    state_next.sync2    = state_reg.sync1;
    state_next.pin_prev = state_reg.sync2;
    // Edges compare the synchronized level with its value one cycle earlier.
    rise = state_reg.sync2 & ~state_reg.pin_prev;
    fall = ~state_reg.sync2 & state_reg.pin_prev;

    // Capture qualification and prescaler.
    cap_hit = 1'b0;
    if (is_cap) begin
      unique case (mode[1:0])
        CCU_CAP_FALL: cap_hit = fall;
        CCU_CAP_RISE: cap_hit = rise;
        CCU_CAP_PS4: begin
          // Count is not cleared on a prescale change, so switching
          // straight between settings can fire early.
          if (rise) begin
            if (state_reg.ps_cnt >= CCU_PS4_LAST) begin
              cap_hit           = 1'b1;
              state_next.ps_cnt = '0;
            end else begin
              state_next.ps_cnt = state_reg.ps_cnt + 4'h1;
            end
          end
        end
        CCU_CAP_PS16: begin
          // The sixteenth rise fires only at the exact end count.
          if (rise) begin
            if (state_reg.ps_cnt == CCU_PS16_LAST) begin
              cap_hit           = 1'b1;
              state_next.ps_cnt = '0;
            end else begin
              state_next.ps_cnt = state_reg.ps_cnt + 4'h1;
            end
          end
        end
      endcase
    end else begin
      // Outside capture the prescaler holds zero.
      state_next.ps_cnt = '0;
    end

    // Continuous compare against the shared timer_one count.
    match     = is_cmp && (timer_one_count_in == {state_reg.vhigh, state_reg.vlow});
    // Only the rising of match sets the flag and the latch, so a timer that parks on the value
    // sets the flag once instead of on every cycle.
    match_evt = match & ~state_reg.match_prev;
    state_next.match_prev = match;

    // Pin drive only in set and clear modes.
    state_next.pin_oe = (mode == CCU_MODE_SET) || (mode == CCU_MODE_CLR);
    if (match_evt && mode == CCU_MODE_SET) begin
      state_next.latch = 1'b1;
    end else if (match_evt && mode == CCU_MODE_CLR) begin
      state_next.latch = 1'b0;
    end

    // Trigger follows the match; it is sampled at each edge, so a
    // match removed before the edge never resets the timer.
    state_next.trig = match && (mode == CCU_MODE_TRIG);
    state_next.adc  = match && (mode == CCU_MODE_TRIG) && adc_enable_in;

    // PWM duty value for the external generator.
    // The waveform itself is made outside; only the ten-bit duty word leaves here.
    state_next.duty = is_pwm ? {state_reg.vlow, state_reg.ctrl[CCU_DUTY_MSB:CCU_DUTY_LSB]} : 10'h000;

    // Bus answer: waitrequest drops one cycle after the request.
    // Every request sees one wait state, so back-to-back accesses take two cycles.
    // Read data are taken at the first edge and stand while waitrequest is low.
    state_next.wait_req = ~(bus_req & state_reg.wait_req);
    if (avs_req_in.read && state_reg.wait_req) begin
      state_next.rdata = read_mux(avs_req_in.address, state_reg);
    end

    // Register writes take effect at the completing edge.
    // Only the low byte lane holds a register; the other lanes are ignored.
    if (commit && avs_req_in.write && avs_req_in.byteenable[0]) begin
      unique case (avs_req_in.address)
        CCU_OFF_CTRL: begin
          state_next.ctrl = avs_req_in.writedata[7:0] & CCU_CTRL_WMASK;
          if (avs_req_in.writedata[CCU_MODE_MSB:0] == CCU_MODE_OFF) begin
            state_next.latch = 1'b0;
          end
        end
        CCU_OFF_VLOW:  state_next.vlow = avs_req_in.writedata[7:0];
        CCU_OFF_VHIGH: state_next.vhigh = avs_req_in.writedata[7:0];
        CCU_OFF_STAT: begin
          if (avs_req_in.writedata[CCU_STAT_FLAG]) begin
            state_next.flag = 1'b0;
          end
        end
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end

    // A capture overwrites the pair even over a same-cycle write.
    // Dropping it would lose an edge time that software cannot recover.
    if (cap_hit) begin
      state_next.vhigh = timer_one_count_in[15:8];
      state_next.vlow  = timer_one_count_in[7:0];
    end

    // Hardware set wins over a software clear in the same cycle.
    if (cap_hit || match_evt) begin
      state_next.flag = 1'b1;
    end

    // Off: internal state is held in its reset condition.
    // The value pair and the flag survive, so software can still read a capture.
    if (mode == CCU_MODE_OFF) begin
      state_next.ps_cnt     = '0;
      state_next.latch      = 1'b0;
      state_next.match_prev = 1'b0;
    end
  end

  // State register.
  // Waitrequest rests high, so no request can complete in its first cycle.
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg          <= '0;
      state_reg.ctrl     <= CCU_BYTE_RST;
      state_reg.wait_req <= 1'b1;
      state_reg.rdata    <= CCU_WORD_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output comes from a state flip-flop.
  // Trigger and timer reset share one flop, so they can never part.
  assign avs_waitrequest_out = state_reg.wait_req;
  assign avs_readdata_out    = state_reg.rdata;
  assign event_pin_out       = state_reg.latch;
  assign event_pin_oe_out    = state_reg.pin_oe;
  assign event_flag_out      = state_reg.flag;
  assign special_event_out   = state_reg.trig;
  assign timer_one_reset_out = state_reg.trig;
  assign adc_start_out       = state_reg.adc;
  assign duty_value_out      = state_reg.duty;

  // Checks, all on the system clock and disabled in reset.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  a_off_clears_state: assert property (
    (mode == CCU_MODE_OFF) |=> (state_reg.ps_cnt == 4'h0) && !event_pin_out)
    else $error("off mode left state set");

  a_reserved_no_action: assert property (
    (state_reg.ctrl[3:2] == 2'b00) |=> !special_event_out && !event_pin_oe_out && !adc_start_out)
    else $error("reserved mode acted");

  a_rise_captures: assert property (
    (mode == CCU_MODE_RISE) && rise |=> event_flag_out
      && ({state_reg.vhigh, state_reg.vlow} == $past(timer_one_count_in)))
    else $error("rising edge not captured");

  a_ps4_bound: assert property (
    is_cap && (mode[1:0] == CCU_CAP_PS4) && rise && (state_reg.ps_cnt < CCU_PS4_LAST) |-> !cap_hit)
    else $error("prescale four fired early");

  a_set_on_match: assert property (
    match_evt && (mode == CCU_MODE_SET) && !wr_ctrl |=> event_pin_out && event_flag_out)
    else $error("set mode did not drive high");

  a_clear_on_match: assert property (
    match_evt && (mode == CCU_MODE_CLR) && !(commit && avs_req_in.write) |=> !event_pin_out && event_flag_out)
    else $error("clear mode did not drive low");

  a_soft_no_pin: assert property (
    (mode == CCU_MODE_SOFT) |=> !event_pin_oe_out)
    else $error("soft mode drove the pin");

  a_trigger_on_match: assert property (
    match && (mode == CCU_MODE_TRIG) |=> special_event_out && timer_one_reset_out
      && (adc_start_out == $past(adc_enable_in)))
    else $error("special trigger missing");

  a_duty_compose: assert property (
    is_pwm |=> duty_value_out == {$past(state_reg.vlow), $past(state_reg.ctrl[5:4])})
    else $error("duty value wrong");

  a_ctrl_top_zero: assert property (
    state_reg.ctrl[7:6] == 2'b00)
    else $error("control bits 7-6 not zero");

  a_capture_copies: assert property (
    cap_hit |=> {state_reg.vhigh, state_reg.vlow} == $past(timer_one_count_in))
    else $error("capture value wrong");

  a_flag_sticky: assert property (
    event_flag_out && !(commit && avs_req_in.write && avs_req_in.address == CCU_OFF_STAT) |=> event_flag_out)
    else $error("flag cleared by hardware");

  a_sync_delay: assert property (
    rise |-> $past(event_pin_in, 2) && !$past(event_pin_in, 3))
    else $error("edge not from synchronized pin");

  a_bus_answer: assert property (
    bus_req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");

  a_wait_idle_high: assert property (
    !bus_req |=> avs_waitrequest_out)
    else $error("bus answer without request");

  // Capture, prescaler and reserved-mode checks.
  a_fall_captures: assert property (
    is_cap && (mode[1:0] == CCU_CAP_FALL) && fall |=> event_flag_out
      && ({state_reg.vhigh, state_reg.vlow} == $past(timer_one_count_in)))
    else $error("falling edge not captured");

  a_ps16_bound: assert property (
    is_cap && (mode[1:0] == CCU_CAP_PS16) && rise && (state_reg.ps_cnt != CCU_PS16_LAST)
      |=> (state_reg.ps_cnt == $past(state_reg.ps_cnt) + 4'h1))
    else $error("prescale sixteen count wrong");

  a_ps16_fires: assert property (
    is_cap && (mode[1:0] == CCU_CAP_PS16) && rise && (state_reg.ps_cnt == CCU_PS16_LAST)
      |=> event_flag_out && (state_reg.ps_cnt == 4'h0))
    else $error("prescale sixteen did not fire");

  a_not_cap_clear: assert property (
    !is_cap |=> (state_reg.ps_cnt == 4'h0))
    else $error("prescaler kept outside capture");

  a_prescale_keep: assert property (
    is_cap && !rise |=> (state_reg.ps_cnt == $past(state_reg.ps_cnt)))
    else $error("prescaler lost its count");

  a_reserved_idle: assert property (
    (mode[3:2] == 2'h0) && !wr_stat |=> (event_flag_out == $past(event_flag_out)))
    else $error("reserved mode moved the flag");

  // Compare, trigger and PWM checks.
  a_soft_keeps_latch: assert property (
    match_evt && (mode == CCU_MODE_SOFT) && !wr_ctrl |=> event_flag_out
      && (event_pin_out == $past(event_pin_out)))
    else $error("soft mode moved the latch");

  a_oe_set_clear: assert property (
    (mode == CCU_MODE_SET) || (mode == CCU_MODE_CLR) |=> event_pin_oe_out)
    else $error("compare output not driven");

  a_trigger_drops: assert property (
    !match |=> !special_event_out && !timer_one_reset_out && !adc_start_out)
    else $error("trigger outlived the match");

  a_pwm_quiet: assert property (
    is_pwm |=> !special_event_out && !event_pin_oe_out && !adc_start_out)
    else $error("PWM mode used the compare path");

  a_duty_idle: assert property (
    !is_pwm |=> (duty_value_out == 10'h000))
    else $error("duty value outside PWM");

  // Register and flag checks.
  a_zero_clears_latch: assert property (
    wr_ctrl && (avs_req_in.writedata[CCU_MODE_MSB:0] == CCU_MODE_OFF) |=> !event_pin_out)
    else $error("latch kept after zero write");

  a_event_sets_flag: assert property (
    cap_hit || match_evt |=> event_flag_out)
    else $error("event did not set the flag");

  a_flag_write_clear: assert property (
    wr_stat && avs_req_in.writedata[CCU_STAT_FLAG] && !cap_hit && !match_evt |=> !event_flag_out)
    else $error("flag not cleared by software");

endmodule

// ==== verification/ccu_pin_model.sv ====
`timescale 1ns/1ps

// Pad model of the event pin: an outside source drives it unless the unit takes the pad over.
module ccu_pin_model (
  input  wire logic src_level_in,  // Level that the outside event source drives.
  input  wire logic unit_level_in, // Compare output latch of the unit.
  input  wire logic unit_oe_in,    // High while the unit drives the pad.
  output logic      pad_level_out  // Level that the unit sees back on the pad.
);
  // The unit wins while it drives, so its own output changes come back as pad edges.
  assign pad_level_out = unit_oe_in ? unit_level_in : src_level_in;
endmodule

// ==== verification/tb_capture_compare_unit.sv ====
`timescale 1ns/1ps

// Self-checking bench: one table of mode cases, then hand-written corner cases.
module tb_capture_compare_unit import ccu_pkg::*; ();
  logic         clk, rst;            // System clock and reset.
  ccu_avs_req_t req;                 // Avalon-MM request from the bench.
  logic         wait_o;              // Avalon-MM waitrequest.
  logic [31:0]  rdata, q;            // Read data port and the value that the last read took.
  logic [15:0]  tm;                  // Timer count; moves only on clock edges.
  logic         adc_en, src, pad;    // Converter enable, outside source level, pad level.
  logic         pin_o, pin_oe, flag_o, sev_o, trst_o, adc_o;
  logic [9:0]   duty_o;              // Duty value for the wave generator.
  logic [2:0]   s;                   // Trigger outputs sampled in mid-match.
  int           bad_count, total_checks;

  // A case: mode byte, pin pulses, expected {flag, latch, drive, trigger}, expected low value byte.
  typedef struct packed {logic [7:0] mode; logic [4:0] pulses; logic [3:0] exp; logic [7:0] vlow;} ccu_row_t;
  localparam ccu_row_t ROWS [15] = '{
    '{8'h00, 5'h02, 4'h0, 8'h50}, '{8'h01, 5'h02, 4'h0, 8'h50}, '{8'h02, 5'h02, 4'h0, 8'h50},
    '{8'h03, 5'h02, 4'h0, 8'h50}, '{8'h04, 5'h01, 4'h8, 8'h34}, '{8'h05, 5'h01, 4'h8, 8'h34},
    '{8'h06, 5'h03, 4'h0, 8'h50}, '{8'h06, 5'h04, 4'h8, 8'h34}, '{8'h07, 5'h0F, 4'h0, 8'h50},
    '{8'h07, 5'h10, 4'h8, 8'h34}, '{8'h08, 5'h01, 4'hE, 8'h50}, '{8'h09, 5'h01, 4'hA, 8'h50},
    '{8'h0A, 5'h01, 4'h8, 8'h50}, '{8'h0B, 5'h01, 4'h9, 8'h50}, '{8'h0C, 5'h01, 4'h0, 8'h50}};

  ccu_capture_compare #(.TIMER_W(16)) i_dut (
    .ref_clk_in(clk), .reset_in(rst), .avs_req_in(req), .avs_waitrequest_out(wait_o),
    .avs_readdata_out(rdata), .timer_one_count_in(tm), .adc_enable_in(adc_en), .event_pin_in(pad),
    .event_pin_out(pin_o), .event_pin_oe_out(pin_oe), .event_flag_out(flag_o), .special_event_out(sev_o),
    .timer_one_reset_out(trst_o), .adc_start_out(adc_o), .duty_value_out(duty_o));
  ccu_pin_model i_pad (.src_level_in(src), .unit_level_in(pin_o), .unit_oe_in(pin_oe), .pad_level_out(pad));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Prints the verdict and ends the run; every exit passes through here.
  task automatic summarize();
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Counts one comparison and reports a mismatch at once.
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      bad_count++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One Avalon-MM transfer; the first edge keeps release and the next request in separate steps.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
    do begin
      @(posedge clk);
      n++;
    end while (wait_o !== 1'b0 && n < 40);
    q = rdata;
    req <= '0;
    if (n >= 40) begin
      bad_count++;
      summarize();
    end
  endtask

  // One outside pulse, long enough to pass the pin synchroniser.
  task automatic pulse();
    src <= 1'b1;
    tick(4);
    src <= 1'b0;
    tick(4);
  endtask

  // Holds a compare match for a few cycles and samples the trigger outputs inside it.
  task automatic hit();
    tm <= 16'h0050;
    tick(3);
    s = {sev_o, trst_o, adc_o};
    tick(1);
    tm <= 16'h1234;
    tick(3);
  endtask

  // Clean restart of the unit: off first, then the flag cleared, so no stale count or event leaks in.
  task automatic restart(input logic [7:0] mode);
    bus(1'b1, CCU_OFF_CTRL, 32'h0000_0000);
    bus(1'b1, CCU_OFF_STAT, 32'h0000_0001);
    bus(1'b1, CCU_OFF_CTRL, {24'h00_0000, mode});
  endtask

  initial begin
    rst = 1'b1;
    req = '0;
    tm = 16'h1234;
    adc_en = 1'b1;
    src = 1'b0;
    bad_count = 0;
    total_checks = 0;
    tick(10);
    rst <= 1'b0;
    tick(1);
    chk({15'h0000, flag_o, pin_o, pin_oe, sev_o, trst_o, adc_o, duty_o, wait_o}, 32'h0000_0001);
    chk(rdata, 32'h0000_0000);
    bus(1'b0, CCU_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // Table of mode cases.
    foreach (ROWS[i]) begin
      bus(1'b1, CCU_OFF_VLOW, 32'h0000_0050);
      bus(1'b1, CCU_OFF_VHIGH, 32'h0000_0000);
      restart(ROWS[i].mode);
      repeat (ROWS[i].pulses) pulse();
      hit();
      chk({29'h0, s}, {29'h0, {3{ROWS[i].exp[0]}}});
      chk({29'h0, sev_o, trst_o, adc_o}, 32'h0000_0000);
      chk({29'h0, flag_o, pin_oe, pin_o}, {29'h0, ROWS[i].exp[3], ROWS[i].exp[1], ROWS[i].exp[2]});
      bus(1'b0, CCU_OFF_STAT, 32'h0000_0000);
      chk(q, {30'h0, ROWS[i].exp[2], ROWS[i].exp[3]});
      bus(1'b0, CCU_OFF_VLOW, 32'h0000_0000);
      chk(q, {24'h00_0000, ROWS[i].vlow});
    end
    // Two captures without a read in between: the later count wins, all 16 bits.
    restart(8'h05);
    tm <= 16'hA1B2;
    pulse();
    tm <= 16'hC3D4;
    pulse();
    bus(1'b0, CCU_OFF_VLOW, 32'h0000_0000);
    chk(q, 32'h0000_00D4);
    bus(1'b0, CCU_OFF_VHIGH, 32'h0000_0000);
    chk(q, 32'h0000_00C3);
    tick(20);
    chk({31'h0, flag_o}, 32'h0000_0001);
    bus(1'b1, CCU_OFF_STAT, 32'h0000_0001);
    bus(1'b0, CCU_OFF_STAT, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // Direct prescaler switch keeps the edge count: 2 edges under 4, then 14 more under 16.
    restart(8'h06);
    repeat (2) pulse();
    bus(1'b1, CCU_OFF_CTRL, 32'h0000_0007);
    repeat (13) pulse();
    chk({31'h0, flag_o}, 32'h0000_0000);
    pulse();
    chk({31'h0, flag_o}, 32'h0000_0001);
    // Set then clear on match without passing through the off mode.
    restart(8'h08);
    bus(1'b1, CCU_OFF_VLOW, 32'h0000_0050);
    bus(1'b1, CCU_OFF_VHIGH, 32'h0000_0000);
    hit();
    chk({30'h0, pin_oe, pin_o}, 32'h0000_0003);
    bus(1'b1, CCU_OFF_CTRL, 32'h0000_0009);
    hit();
    chk({30'h0, pin_oe, pin_o}, 32'h0000_0002);
    // Trigger with the converter off: the timer reset fires, no conversion starts.
    restart(8'h0B);
    adc_en <= 1'b0;
    hit();
    chk({29'h0, s}, 32'h0000_0006);
    adc_en <= 1'b1;
    // Duty value, unimplemented control bits, reserved mode and an unmapped address.
    bus(1'b1, CCU_OFF_CTRL, 32'h0000_00FF);
    bus(1'b0, CCU_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_003F);
    bus(1'b1, CCU_OFF_VLOW, 32'h0000_00AB);
    tick(2);
    chk({22'h00_0000, duty_o}, 32'h0000_02AF);
    bus(1'b1, CCU_OFF_CTRL, 32'h0000_0033);
    tick(2);
    chk({22'h00_0000, duty_o}, 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    // Second reset in mid-run returns everything to its reset values.
    bus(1'b1, CCU_OFF_CTRL, 32'h0000_000C);
    tick(2);
    chk({22'h00_0000, duty_o}, 32'h0000_02AC);
    rst <= 1'b1;
    tick(2);
    chk({21'h00_0000, duty_o, wait_o}, 32'h0000_0001);
    rst <= 1'b0;
    bus(1'b0, CCU_OFF_CTRL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    summarize();
  end
endmodule
